// ==== pgfs_pkg.sv ====
// Constants and carrier types for the port group one function select block.
// Assumes a 32-bit Avalon-MM register bus with word-aligned registers.
package pgfs_pkg;
  localparam int unsigned NPIN = 5;
  localparam int unsigned AW = 16;
  // Register indices; byte address is four times the index.
  localparam logic [13:0] IDX_OE = 14'h28ac;
  localparam logic [13:0] IDX_IE = 14'h28ad;
  localparam logic [13:0] IDX_OD = 14'h28ae;
  localparam logic [13:0] IDX_LVL = 14'h28af;
  localparam logic [13:0] IDX_SEL0 = 14'h28c4;
  localparam logic [13:0] IDX_SEL1 = 14'h28c5;
  localparam logic [13:0] IDX_SEL2 = 14'h28c6;
  localparam logic [13:0] IDX_SEL3 = 14'h28c7;
  localparam logic [13:0] IDX_SEL4 = 14'h28c8;
  // Values after reset.
  localparam logic [4:0] RST_OE = 5'h1f;
  localparam logic [4:0] RST_IE = 5'h00;
  localparam logic [4:0] RST_OD = 5'h1f;
  localparam logic [4:0] RST_LVL = 5'h00;
  localparam logic [2:0] RST_SEL = 3'h0;
  // Select codes.
  localparam logic [2:0] SEL_GPIO = 3'h0;
  localparam logic [1:0] S0_PPS = 2'h1;
  localparam logic [2:0] S1_RX1 = 3'h2;
  localparam logic [2:0] S1_TMR1 = 3'h3;
  localparam logic [2:0] S1_IRQ2 = 3'h4;
  localparam logic [2:0] S2_TX1 = 3'h2;
  localparam logic [2:0] S2_TRIG2 = 3'h3;
  localparam logic [2:0] S2_IRQ3 = 3'h4;
  localparam logic [2:0] S3_CF2 = 3'h1;
  localparam logic [2:0] S3_RX5 = 3'h2;
  localparam logic [2:0] S3_IRQ0 = 3'h3;
  localparam logic [2:0] S3_CF1 = 3'h4;
  localparam logic [2:0] S3_PPS = 3'h5;
  localparam logic [2:0] S3_PLL = 3'h6;
  localparam logic [1:0] S4_PLL = 2'h1;
  localparam logic [1:0] S4_TX5 = 2'h2;
  localparam logic [1:0] S4_IRQ1 = 2'h3;

  typedef struct packed {
    logic second_pulse;
    logic serial_one_transmit;
    logic serial_five_transmit;
    logic first_path_energy_pulse;
    logic second_path_energy_pulse;
    logic divided_pll_pulse;
  } pgfs_fn_out_t;

  typedef struct packed {
    logic serial_one_receive;
    logic serial_five_receive;
    logic timer_one_external;
    logic timer_two_trigger;
    logic [3:0] io_irq;
  } pgfs_fn_in_t;
endpackage : pgfs_pkg

// ==== pgfs_top.sv ====
// Pin multiplexer for the five pins of port group one, with its registers.
// Assumes an Avalon-MM master on mclk_i and asynchronous pin levels.
//
// Overview of operation
// - With input enabled, level register shows pin level regardless of routed function.
// - Pin zero select: 00 plain IO, 01 pulse-per-second output.
// - Pulse-per-second gives uncalibrated pulses in seconds 1 to 29 of 30.
// - Thirtieth second pulse is corrected so the mean period is one second.
// - Pin one select: 000 IO, 010 serial one rx, 011 timer one, 100 irq 2.
// - Pin two: 000 IO, 001 reserved, 010 serial one tx, 011 timer two trigger, 100 irq 3.
// - Pin three: 000 IO, 001 path two pulse, 010 serial five rx, 011 irq 0, 100 path one.
// - Pin three: 101 pulse-per-second out, 110 divided PLL pulse out.
// - Divided PLL pulse follows the divided PLL clock or one-second PLL pulses.
// - Pin four: 00 IO, 01 divided PLL pulse, 10 serial five tx, 11 irq 1.
// - Input enable bit set turns input on; all reset to zero.
// - Output enable bit set turns output off; all reset to one.
`timescale 1ns/10ps
module pgfs_top
  import pgfs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NPIN-1:0] pin_in_i,
  output logic [NPIN-1:0] pin_out_o,
  output logic [NPIN-1:0] pin_oe_n_o,
  input wire pgfs_fn_out_t fn_out_i,
  output pgfs_fn_in_t fn_in_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a level counts once stages two and three agree.
  logic [NPIN-1:0] sync1_q, sync2_q, sync3_q, filt_q, filt_d;
  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_sync
      always_ff @(posedge mclk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
          filt_q[g] <= 1'b0;
        end
        else
        begin
          sync1_q[g] <= pin_in_i[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          filt_q[g] <= filt_d[g];
        end
      end
      assign filt_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : filt_q[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus slave; one wait cycle per access.
  logic [4:0] oe_q, oe_d, ie_q, ie_d, od_q, od_d, lvl_q, lvl_d;
  logic [1:0] sel0_q, sel0_d, sel4_q, sel4_d;
  logic [2:0] sel1_q, sel1_d, sel2_q, sel2_d, sel3_q, sel3_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [13:0] idx;
  logic wr_en;

  assign idx = avs_address_i[AW-1:2];
  assign wr_en = avs_write_i && !wait_q && avs_byteenable_i[0];

  function automatic logic [7:0] read_reg(input logic [13:0] i);
    unique case (i)
      IDX_OE: read_reg = {3'h0, oe_q};
      IDX_IE: read_reg = {3'h0, ie_q};
      IDX_OD: read_reg = {3'h0, od_q};
      IDX_LVL: read_reg = {3'h0, lvl_q};
      IDX_SEL0: read_reg = {6'h00, sel0_q};
      IDX_SEL1: read_reg = {5'h00, sel1_q};
      IDX_SEL2: read_reg = {5'h00, sel2_q};
      IDX_SEL3: read_reg = {5'h00, sel3_q};
      IDX_SEL4: read_reg = {6'h00, sel4_q};
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  always_comb
  begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    oe_d = oe_q;
    ie_d = ie_q;
    od_d = od_q;
    sel0_d = sel0_q;
    sel1_d = sel1_q;
    sel2_d = sel2_q;
    sel3_d = sel3_q;
    sel4_d = sel4_q;
    if ((avs_read_i || avs_write_i) && wait_q)
    begin
      wait_d = 1'b0;
      rdata_d = avs_read_i ? {24'h000000, read_reg(idx)} : 32'h00000000;
    end
    if (wr_en)
    begin
      unique case (idx)
        IDX_OE: oe_d = avs_writedata_i[4:0];
        IDX_IE: ie_d = avs_writedata_i[4:0];
        IDX_OD: od_d = avs_writedata_i[4:0];
        IDX_SEL0: sel0_d = avs_writedata_i[1:0];
        IDX_SEL1: sel1_d = avs_writedata_i[2:0];
        IDX_SEL2: sel2_d = avs_writedata_i[2:0];
        IDX_SEL3: sel3_d = avs_writedata_i[2:0];
        IDX_SEL4: sel4_d = avs_writedata_i[1:0];
        default: ;
      endcase
    end
    // Level register ignores writes; it tracks enabled pins only.
    lvl_d = (lvl_q & ~ie_q) | (filt_q & ie_q);
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
      oe_q <= RST_OE;
      ie_q <= RST_IE;
      od_q <= RST_OD;
      lvl_q <= RST_LVL;
      sel0_q <= RST_SEL[1:0];
      sel1_q <= RST_SEL;
      sel2_q <= RST_SEL;
      sel3_q <= RST_SEL;
      sel4_q <= RST_SEL[1:0];
    end
    else
    begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      oe_q <= oe_d;
      ie_q <= ie_d;
      od_q <= od_d;
      lvl_q <= lvl_d;
      sel0_q <= sel0_d;
      sel1_q <= sel1_d;
      sel2_q <= sel2_d;
      sel3_q <= sel3_d;
      sel4_q <= sel4_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Routing. Input-function pins are not driven; reserved codes float.
  logic [NPIN-1:0] out_q, out_d, oen_q, oen_d;
  pgfs_fn_in_t fin_q, fin_d;

  always_comb
  begin
    out_d = od_q;
    oen_d = oe_q;
    fin_d = '{serial_one_receive: 1'b1, serial_five_receive: 1'b1,
              timer_one_external: 1'b0, timer_two_trigger: 1'b0, io_irq: 4'h0};
    // Pin zero.
    if (sel0_q == S0_PPS)
    begin
      out_d[0] = fn_out_i.second_pulse;
      oen_d[0] = 1'b0;
    end
    else if (sel0_q != SEL_GPIO[1:0])
    begin
      oen_d[0] = 1'b1;
    end
    // Pin one.
    if (sel1_q != SEL_GPIO)
    begin
      oen_d[1] = 1'b1;
    end
    unique case (sel1_q)
      S1_RX1: fin_d.serial_one_receive = filt_q[1];
      S1_TMR1: fin_d.timer_one_external = filt_q[1];
      S1_IRQ2: fin_d.io_irq[2] = filt_q[1];
      default: ;
    endcase
    // Pin two.
    if (sel2_q == S2_TX1)
    begin
      out_d[2] = fn_out_i.serial_one_transmit;
      oen_d[2] = 1'b0;
    end
    else if (sel2_q != SEL_GPIO)
    begin
      oen_d[2] = 1'b1;
    end
    if (sel2_q == S2_TRIG2)
    begin
      fin_d.timer_two_trigger = filt_q[2];
    end
    if (sel2_q == S2_IRQ3)
    begin
      fin_d.io_irq[3] = filt_q[2];
    end
    // Pin three.
    if (sel3_q != SEL_GPIO)
    begin
      oen_d[3] = 1'b1;
    end
    unique case (sel3_q)
      S3_CF2:
      begin
        out_d[3] = fn_out_i.second_path_energy_pulse;
        oen_d[3] = 1'b0;
      end
      S3_RX5: fin_d.serial_five_receive = filt_q[3];
      S3_IRQ0: fin_d.io_irq[0] = filt_q[3];
      S3_CF1:
      begin
        out_d[3] = fn_out_i.first_path_energy_pulse;
        oen_d[3] = 1'b0;
      end
      S3_PPS:
      begin
        out_d[3] = fn_out_i.second_pulse;
        oen_d[3] = 1'b0;
      end
      S3_PLL:
      begin
        out_d[3] = fn_out_i.divided_pll_pulse;
        oen_d[3] = 1'b0;
      end
      default: ;
    endcase
    // Pin four.
    unique case (sel4_q)
      S4_PLL:
      begin
        out_d[4] = fn_out_i.divided_pll_pulse;
        oen_d[4] = 1'b0;
      end
      S4_TX5:
      begin
        out_d[4] = fn_out_i.serial_five_transmit;
        oen_d[4] = 1'b0;
      end
      S4_IRQ1:
      begin
        fin_d.io_irq[1] = filt_q[4];
        oen_d[4] = 1'b1;
      end
      default: ;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      out_q <= RST_OD;
      oen_q <= RST_OE;
      fin_q <= '{serial_one_receive: 1'b1, serial_five_receive: 1'b1,
                 timer_one_external: 1'b0, timer_two_trigger: 1'b0, io_irq: 4'h0};
    end
    else
    begin
      out_q <= out_d;
      oen_q <= oen_d;
      fin_q <= fin_d;
    end
  end

  assign pin_out_o = out_q;
  assign pin_oe_n_o = oen_q;
  assign fn_in_o = fin_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  a_level_follow: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ie_q[3] && sel3_q == S3_RX5 && sync2_q[3] == sync3_q[3]) ##1 ie_q[3]
      |=> lvl_q[3] == $past(sync3_q[3], 2))
    else $error("level register does not follow an enabled pin");
  a_level_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !ie_q[1] |=> $stable(lvl_q[1]))
    else $error("disabled input changed the level register");
  a_pps_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sel0_q == S0_PPS |=> !pin_oe_n_o[0] && pin_out_o[0] == $past(fn_out_i.second_pulse))
    else $error("pin zero does not carry the second pulse");
  a_rx_one: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sel1_q == S1_RX1 |=> fn_in_o.serial_one_receive == $past(filt_q[1]) && pin_oe_n_o[1])
    else $error("pin one does not feed serial one receive");
  a_tx_one: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sel2_q == S2_TX1 |=> pin_out_o[2] == $past(fn_out_i.serial_one_transmit))
    else $error("pin two does not carry serial one transmit");
  a_reserved_float: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sel2_q == 3'h1 |=> pin_oe_n_o[2])
    else $error("reserved code drives pin two");
  a_cf_two: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sel3_q == S3_CF2 |=> pin_out_o[3] == $past(fn_out_i.second_path_energy_pulse))
    else $error("pin three does not carry path two pulse");
  a_pll_three: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sel3_q == S3_PLL |=> !pin_oe_n_o[3] && pin_out_o[3] == $past(fn_out_i.divided_pll_pulse))
    else $error("pin three does not carry the PLL pulse");
  a_tx_five: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sel4_q == S4_TX5 |=> pin_out_o[4] == $past(fn_out_i.serial_five_transmit))
    else $error("pin four does not carry serial five transmit");
  a_gpio_enable: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    sel1_q == SEL_GPIO |=> pin_oe_n_o[1] == $past(oe_q[1]) && pin_out_o[1] == $past(od_q[1]))
    else $error("plain pin one ignores its enable or data");
  a_bus_answer: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (avs_read_i || avs_write_i) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer is not one cycle wide");

endmodule : pgfs_top

// ==== pgfs_far.sv ====
// Far-side model of the five pins and of the routed peripheral sources.
// Assumes the bench sets the outside pin levels and the peripheral source values.
`timescale 1ns/10ps
module pgfs_far
  import pgfs_pkg::*;
(
  input wire logic [NPIN-1:0] pin_out_i,
  input wire logic [NPIN-1:0] pin_oe_n_i,
  input wire logic [NPIN-1:0] ext_lvl_i,
  input wire logic [5:0] fn_val_i,
  output logic [NPIN-1:0] pin_lvl_o,
  output pgfs_fn_out_t fn_o
);
  // A driven pin shows the device value, a released one the outside level.
  assign pin_lvl_o = (pin_out_i & ~pin_oe_n_i) | (ext_lvl_i & pin_oe_n_i);
  assign fn_o = pgfs_fn_out_t'(fn_val_i);
endmodule : pgfs_far

// ==== pgfs_top_bench.sv ====
// Self-checking bench for the port group one pin multiplexer.
// Assumes pgfs_top and the far-side model pgfs_far.
`timescale 1ns/10ps
module pgfs_top_bench;
  import pgfs_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [AW-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [3:0] be = '0;
  logic [31:0] rdata;
  logic wait_o;
  logic [4:0] pin_in;
  logic [4:0] pin_out;
  logic [4:0] oe_n;
  logic [4:0] ext = '0;
  logic [5:0] fnv = '0;
  pgfs_fn_out_t fn_out;
  pgfs_fn_in_t fn_in;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [31:0] q;
  // Entries are kind (0 out, 1 in, 2 reserved), pin, code, function bit.
  logic [15:0] tbl [23] = '{16'h0015, 16'h0224, 16'h0311, 16'h0342, 16'h0355, 16'h0360,
    16'h0410, 16'h0423, 16'h1127, 16'h1135, 16'h1142, 16'h1234, 16'h1243, 16'h1326,
    16'h1330, 16'h1431, 16'h2020, 16'h2030, 16'h2110, 16'h2150, 16'h2210, 16'h2250, 16'h2370};

  pgfs_top dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(oe_n),
    .fn_out_i(fn_out), .fn_in_o(fn_in));
  pgfs_far far (.pin_out_i(pin_out), .pin_oe_n_i(oe_n), .ext_lvl_i(ext), .fn_val_i(fnv),
    .pin_lvl_o(pin_in), .fn_o(fn_out));

  initial forever #25 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge mclk_i);
    addr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    be <= b;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (wait_o !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_o !== 1'b0)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask : bus

  task rdc(input logic [13:0] i, input logic [31:0] e);
    bus(1'b0, {i, 2'b00}, 32'h0, 4'hf);
    chk(q, e);
  endtask : rdc

  task wrr(input logic [13:0] i, input logic [31:0] d, input logic [3:0] b = 4'h1);
    bus(1'b1, {i, 2'b00}, d, b);
  endtask : wrr

  task settle;
    repeat (10) @(posedge mclk_i);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rdc(IDX_OE, {27'h0, RST_OE});
    rdc(IDX_IE, {27'h0, RST_IE});
    rdc(IDX_OD, {27'h0, RST_OD});
    rdc(IDX_LVL, {27'h0, RST_LVL});
    for (int p = 0; p < 5; p++)
      rdc(IDX_SEL0 + 14'(p), {29'h0, RST_SEL});
    bus(1'b0, 16'h0000, 32'h0, 4'hf);
    chk(q, 32'h0);
    chk({19'h0, oe_n, fn_in}, {19'h0, 5'h1f, 8'hc0});
    chk({27'h0, pin_out}, {27'h0, RST_OD});
  endtask : t_reset

  task t_levels;
    ext <= 5'h15;
    wrr(IDX_IE, 32'h1f);
    settle();
    rdc(IDX_LVL, 32'h15);
    wrr(IDX_IE, 32'h0);
    ext <= 5'h0a;
    settle();
    rdc(IDX_LVL, 32'h15);
    wrr(IDX_LVL, 32'h0);
    wrr(IDX_IE, 32'h1f, 4'h0);
    rdc(IDX_IE, 32'h0);
    rdc(IDX_LVL, 32'h15);
  endtask : t_levels

  task t_route;
    logic [3:0] k;
    logic [3:0] p;
    logic [3:0] b;
    logic [4:0] m;
    logic [4:0] lv;
    logic [7:0] ef;
    wrr(IDX_IE, 32'h1f);
    for (int i = 0; i < 23; i++)
    begin
      {k, p} = tbl[i][15:8];
      b = tbl[i][3:0];
      m = 5'h1 << p;
      wrr(IDX_SEL0 + {10'h0, p}, {28'h0, tbl[i][7:4]});
      for (int v = 0; v < 2; v++)
      begin
        lv = v ? 5'h00 : 5'h1f;
        ext <= lv;
        fnv <= v ? 6'h3f : 6'h00;
        settle();
        ef = 8'hc0;
        if (k == 4'h1)
          ef = (ef & ~(8'h1 << b)) | ({7'h0, lv[p]} << b);
        if (k == 4'h0)
          lv = (lv & ~m) | (v ? m : 5'h0);
        chk({19'h0, oe_n, fn_in}, {19'h0, k == 4'h0 ? ~m : 5'h1f, ef});
        if (k == 4'h0)
          chk({31'h0, pin_out[p]}, 32'(v));
        rdc(IDX_LVL, {27'h0, lv});
      end
      wrr(IDX_SEL0 + {10'h0, p}, 32'h0);
    end
  endtask : t_route

  task t_upper;
    wrr(IDX_SEL0, 32'hff);
    rdc(IDX_SEL0, 32'h03);
    wrr(IDX_SEL1, 32'hff);
    rdc(IDX_SEL1, 32'h07);
    wrr(IDX_SEL0, 32'h0);
    wrr(IDX_SEL1, 32'h0);
    wrr(IDX_IE, 32'h0);
  endtask : t_upper

  // Plain pins: cleared enable bits drive the data register, set ones release the pin.
  task t_gpio;
    wrr(IDX_OD, 32'h0a);
    wrr(IDX_OE, 32'h12);
    wrr(IDX_IE, 32'h1f);
    ext <= 5'h15;
    settle();
    rdc(IDX_OE, 32'h12);
    rdc(IDX_OD, 32'h0a);
    chk({27'h0, oe_n}, 32'h12);
    chk({27'h0, pin_out}, 32'h0a);
    rdc(IDX_LVL, 32'h18);
  endtask : t_gpio

  // A second reset in mid-run must bring every written register back to its reset value.
  task t_midreset;
    wrr(IDX_SEL3, {29'h0, S3_PLL});
    rstn_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset();
  endtask : t_midreset

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_levels();
    t_route();
    t_upper();
    t_gpio();
    t_midreset();
    stop_test();
  end
endmodule : pgfs_top_bench
